/* verilog/watch_pkg.sv */
/*
  Shared constants and types of the watch and interval timer: register
  addresses, field positions, reset values, clock select codes and the
  main clock divider periods.
  Assumes a single 50 MHz main clock and byte-wide register access.
*/
`default_nettype none

package watch_pkg;

  // Register addresses as they stand on the internal bus.
  localparam logic [31:0] MODE_CONTROL_ADDR      = 32'h0ffff360;
  localparam logic [31:0] CLOCK_SELECT_ADDR      = 32'hfffff364;
  localparam logic [31:0] FAST_CLOCK_SELECT_ADDR = 32'h0ffff366;

  // Reset values.
  localparam logic [7:0] MODE_CONTROL_RESET      = 8'h00;
  localparam logic [1:0] CLOCK_SELECT_RESET      = 2'h0;
  localparam logic       FAST_CLOCK_SELECT_RESET = 1'b0;

  // Field positions in the mode control register.
  localparam int OPERATION_ENABLE_POS = 0;
  localparam int COUNTER_CONTROL_POS  = 1;
  localparam int TICK_PERIOD_LSB      = 2;
  localparam int INTERVAL_FIELD_LSB   = 4;
  localparam int CLOCK_SOURCE_POS     = 7;

  // Prescaler and counter sizes.
  localparam int PRESCALER_WIDTH = 11;
  localparam int COUNTER_WIDTH   = 5;
  localparam int SEGMENT_BITS    = 9;
  localparam logic [3:0] INTERVAL_BASE_EXP = 4'h4;

  // Watch tick period codes.
  localparam logic [1:0] TICK_EXP14 = 2'h0;
  localparam logic [1:0] TICK_EXP13 = 2'h1;
  localparam logic [1:0] TICK_EXP5  = 2'h2;
  localparam logic [1:0] TICK_EXP4  = 2'h3;

  // Clock select codes {fast, sel1, sel0, source bit}.
  localparam logic [3:0] CLK_MAIN_DIV128 = 4'h0;
  localparam logic [3:0] CLK_SUBCLOCK    = 4'h1;
  localparam logic [3:0] CLK_MAIN_DIV192 = 4'h2;
  localparam logic [3:0] CLK_MAIN_DIV256 = 4'h3;
  localparam logic [3:0] CLK_MAIN_DIV384 = 4'h6;
  localparam logic [3:0] CLK_MAIN_DIV512 = 4'h7;
  localparam logic [3:0] CLK_MAIN_DIV576 = 4'ha;

  // Main clock divider periods in clk cycles.
  localparam logic [9:0] DIV128_PERIOD = 10'h080;
  localparam logic [9:0] DIV192_PERIOD = 10'h0c0;
  localparam logic [9:0] DIV256_PERIOD = 10'h100;
  localparam logic [9:0] DIV384_PERIOD = 10'h180;
  localparam logic [9:0] DIV512_PERIOD = 10'h200;
  localparam logic [9:0] DIV576_PERIOD = 10'h240;

  // One register access from the internal bus.
  typedef struct packed {
    logic [31:0] addr;
    logic        byte_write;
    logic        bit_write;
    logic [2:0]  bit_sel;
    logic        bit_value;
    logic [7:0]  wdata;
    logic        read;
  } bus_req_s;

endpackage

`default_nettype wire

/* verilog/subclock_sync.sv */
/*
  Brings the subclock pin into the main clock domain and gives a one-cycle
  pulse for each settled rising edge.
  Assumes the subclock is far slower than clk.
*/
`timescale 1ns/100ps
`default_nettype none

module subclock_sync (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Pin and result.
  input  wire logic sub_clock_pin,
  output var  logic sub_tick
);

  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic level;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= sub_clock_pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // A level only counts once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      level    <= 1'b0;
      sub_tick <= 1'b0;
    end else begin
      sub_tick <= (sync_b == sync_c) && sync_c && !level;
      if (sync_b == sync_c) begin
        level <= sync_c;
      end
    end
  end

endmodule

`default_nettype wire

/* verilog/clock_source_select.sv */
/*
  Derives the watch count clock enable from either the synchronised
  subclock or a divided main clock.
  Assumes code is stable while run is high; prohibited codes give no ticks.
*/
`timescale 1ns/100ps
`default_nettype none

module clock_source_select (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Control.
  input  wire logic       run,
  input  wire logic [3:0] code,
  input  wire logic       sub_tick,
  // Result.
  output var  logic       count_tick
);
  import watch_pkg::*;

  logic [9:0] div_count;
  logic [9:0] period;
  logic       use_sub;

  always_comb begin
    use_sub = 1'b0;
    period  = 10'h000;
    case (code)
      CLK_MAIN_DIV128: period = DIV128_PERIOD;
      CLK_SUBCLOCK:    use_sub = 1'b1;
      CLK_MAIN_DIV192: period = DIV192_PERIOD;
      CLK_MAIN_DIV256: period = DIV256_PERIOD;
      CLK_MAIN_DIV384: period = DIV384_PERIOD;
      CLK_MAIN_DIV512: period = DIV512_PERIOD;
      CLK_MAIN_DIV576: period = DIV576_PERIOD;
      default:         period = 10'h000;
    endcase
  end

  // The divider restarts whenever the timer stops so a start is phase aligned.
  always_ff @(posedge clk) begin
    if (rst || !run || use_sub || period == 10'h000) begin
      div_count <= 10'h000;
    end else if (div_count == period - 10'h001) begin
      div_count <= 10'h000;
    end else begin
      div_count <= div_count + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      count_tick <= 1'b0;
    end else if (use_sub) begin
      count_tick <= sub_tick;
    end else begin
      count_tick <= (period != 10'h000) && (div_count == period - 10'h001);
    end
  end

endmodule

`default_nettype wire

/* verilog/watch_interval_timer.sv */
/*
  Watch timer with an 11-bit prescaler and a 5-bit counter, producing a
  watch tick interrupt and an interval tick interrupt, both as one-cycle
  pulses on clk. Three byte registers sit on the internal bus.
  Assumes software programs the clock and periods before enabling.
*/
//
// Operation
// - Interval tick period is 2^(4+code) watch clock periods, code 0 to 7.
// - Watch tick period code 00,01,10,11 gives 2^14, 2^13, 2^5, 2^4 periods.
// - Interval tick repeats at its interval independently of the watch tick.
// - Counter control 1 lets the 5-bit counter count; 0 stops and clears it.
// - Operation enable 0 clears prescaler and counter; 1 enables operation.
// - An 11-bit prescaler feeds a 5-bit counter governed by mode control.
// - Reset clears the mode control register.
// - Reset clears fast select register; bits 7..1 read zero, bit 0 is select.
// - Reset clears clock select register; bits 7..2 read zero.
// - Watch clock comes from fast bit, two select bits and mode bit 7.
// - The seven legal select codes map to subclock or fixed main dividers.
// - Watch and interval ticks run together from the shared prescaler.
// - Mode control accepts whole-byte and single-bit writes.
// - Watch tick counting needs both enable and counter control set.
// - First watch tick comes 2^9 periods late; later ones at nominal period.
`timescale 1ns/100ps
`default_nettype none

module watch_interval_timer #(
  parameter bit HAS_FAST_SELECT = 1'b1
) (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst,
  // Internal bus.
  input  wire watch_pkg::bus_req_s bus_req,
  output var  logic [7:0]          rdata,
  // Subclock pin.
  input  wire logic               sub_clock_pin,
  // Interrupt requests.
  output var  logic               watch_tick_irq,
  output var  logic               interval_tick_irq
);
  import watch_pkg::*;

  logic [7:0]                 watch_mode_control;
  logic [1:0]                 watch_clock_select;
  logic                       watch_fast_clock_select;
  logic [PRESCALER_WIDTH-1:0] prescaler;
  logic [COUNTER_WIDTH-1:0]   counter;
  logic                       primed;
  logic                       sub_tick;
  logic                       count_tick;
  logic                       fast_bit;
  logic [3:0]                 clock_code;
  logic                       operation_enable_bit;
  logic                       counter_control_bit;
  logic [1:0]                 tick_period;
  logic [2:0]                 interval_field;
  logic [PRESCALER_WIDTH-1:0] interval_mask;
  logic [11:0]                mask_wide;
  logic [3:0]                 interval_exp;
  logic                       segment_wrap;
  logic                       interval_hit;
  logic                       watch_hit;
  logic                       counting;

  assign operation_enable_bit = watch_mode_control[OPERATION_ENABLE_POS];
  assign counter_control_bit  = watch_mode_control[COUNTER_CONTROL_POS];
  assign tick_period          = watch_mode_control[TICK_PERIOD_LSB +: 2];
  assign interval_field       = watch_mode_control[INTERVAL_FIELD_LSB +: 3];
  assign counting             = operation_enable_bit && counter_control_bit;

  // Register writes.

  always_ff @(posedge clk) begin
    if (rst) begin
      watch_mode_control <= MODE_CONTROL_RESET;
    end else if (bus_req.addr == MODE_CONTROL_ADDR) begin
      if (bus_req.byte_write) begin
        watch_mode_control <= bus_req.wdata;
      end else if (bus_req.bit_write) begin
        watch_mode_control[bus_req.bit_sel] <= bus_req.bit_value;
      end
    end
  end

  // Bit writes to the select registers are not supported and are ignored.
  always_ff @(posedge clk) begin
    if (rst) begin
      watch_clock_select <= CLOCK_SELECT_RESET;
    end else if (bus_req.byte_write && bus_req.addr == CLOCK_SELECT_ADDR) begin
      watch_clock_select <= bus_req.wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      watch_fast_clock_select <= FAST_CLOCK_SELECT_RESET;
    end else if (bus_req.byte_write && bus_req.addr == FAST_CLOCK_SELECT_ADDR) begin
      watch_fast_clock_select <= bus_req.wdata[0];
    end
  end

  assign fast_bit = HAS_FAST_SELECT ? watch_fast_clock_select : 1'b0;

  // Register reads; unused upper bits read as zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus_req.read) begin
      if (bus_req.addr == MODE_CONTROL_ADDR) begin
        rdata <= watch_mode_control;
      end else if (bus_req.addr == CLOCK_SELECT_ADDR) begin
        rdata <= {6'h00, watch_clock_select};
      end else if (bus_req.addr == FAST_CLOCK_SELECT_ADDR && HAS_FAST_SELECT) begin
        rdata <= {7'h00, watch_fast_clock_select};
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // Watch clock source.

  assign clock_code = {fast_bit, watch_clock_select,
                       watch_mode_control[CLOCK_SOURCE_POS]};

  subclock_sync u_subclock_sync (
    .clk           (clk),
    .rst           (rst),
    .sub_clock_pin (sub_clock_pin),
    .sub_tick      (sub_tick)
  );

  // The divider only runs while operation is enabled, to save power when idle.
  clock_source_select u_clock_source_select (
    .clk        (clk),
    .rst        (rst),
    .run        (operation_enable_bit),
    .code       (clock_code),
    .sub_tick   (sub_tick),
    .count_tick (count_tick)
  );

  // Prescaler and counter.

  always_ff @(posedge clk) begin
    if (rst || !operation_enable_bit) begin
      prescaler <= '0;
    end else if (count_tick) begin
      prescaler <= prescaler + 11'h001;
    end
  end

  assign segment_wrap = count_tick && (prescaler[SEGMENT_BITS-1:0] == 9'h1ff);

  // The first segment after start only arms the counter, which delays the
  // first watch tick by one segment of the prescaler.
  always_ff @(posedge clk) begin
    if (rst || !counting) begin
      counter <= '0;
      primed  <= 1'b0;
    end else if (segment_wrap) begin
      if (!primed) begin
        primed <= 1'b1;
      end else begin
        counter <= counter + 5'h01;
      end
    end
  end

  // Tick detection.

  always_comb begin
    interval_exp  = INTERVAL_BASE_EXP + {1'b0, interval_field};
    mask_wide     = (12'h001 << interval_exp) - 12'h001;
    interval_mask = mask_wide[PRESCALER_WIDTH-1:0];
  end

  // The interval tick only needs the prescaler, so it runs alongside the watch tick.
  assign interval_hit = operation_enable_bit && count_tick &&
                        ((prescaler & interval_mask) == interval_mask);

  always_comb begin
    watch_hit = 1'b0;
    unique case (tick_period)
      TICK_EXP14: watch_hit = segment_wrap && (counter == 5'h1f);
      TICK_EXP13: watch_hit = segment_wrap && (counter[3:0] == 4'hf);
      TICK_EXP5:  watch_hit = count_tick && (prescaler[4:0] == 5'h1f);
      TICK_EXP4:  watch_hit = count_tick && (prescaler[3:0] == 4'hf);
    endcase
    watch_hit = watch_hit && counting && primed;
  end

  // Both requests are registered single-cycle pulses on clk.
  always_ff @(posedge clk) begin
    if (rst) begin
      watch_tick_irq    <= 1'b0;
      interval_tick_irq <= 1'b0;
    end else begin
      watch_tick_irq    <= watch_hit;
      interval_tick_irq <= interval_hit;
    end
  end

  // Checks.

  a_watch_irq_pulse: assert property (
    @(posedge clk) disable iff (rst) watch_tick_irq |=> !watch_tick_irq)
    else $error("watch tick request longer than one cycle");

  a_interval_irq_pulse: assert property (
    @(posedge clk) disable iff (rst) interval_tick_irq |=> !interval_tick_irq)
    else $error("interval tick request longer than one cycle");

  a_disable_clears_all: assert property (
    @(posedge clk) disable iff (rst)
    !operation_enable_bit |=> (prescaler == '0) && (counter == '0))
    else $error("prescaler or counter not cleared while disabled");

  a_counter_ctrl_clear: assert property (
    @(posedge clk) disable iff (rst) !counter_control_bit |=> counter == '0)
    else $error("counter not cleared while counter control is low");

  a_watch_needs_both: assert property (
    @(posedge clk) disable iff (rst) !counting |=> !watch_tick_irq)
    else $error("watch tick without enable and counter control");

  a_reset_clears_regs: assert property (
    @(posedge clk) rst |=> (watch_mode_control == 8'h00) &&
      (watch_clock_select == 2'h0) && !watch_fast_clock_select)
    else $error("registers not cleared by reset");

  a_fast_read_zero: assert property (
    @(posedge clk) disable iff (rst)
    bus_req.read && bus_req.addr == FAST_CLOCK_SELECT_ADDR |=> rdata[7:1] == 7'h00)
    else $error("fast select upper bits not zero");

  a_interval_on_tick: assert property (
    @(posedge clk) disable iff (rst)
    interval_tick_irq |-> $past(count_tick) && (($past(prescaler) & $past(interval_mask))
      == $past(interval_mask)))
    else $error("interval tick not at selected prescaler boundary");

  a_first_tick_late: assert property (
    @(posedge clk) disable iff (rst)
    $rose(primed) |-> counter == '0 && !watch_tick_irq)
    else $error("counter advanced before first segment");

  a_bit_write_mode: assert property (
    @(posedge clk) disable iff (rst)
    bus_req.bit_write && !bus_req.byte_write && bus_req.addr == MODE_CONTROL_ADDR
    |=> watch_mode_control[$past(bus_req.bit_sel)] == $past(bus_req.bit_value))
    else $error("single bit write to mode control lost");

  a_prescaler_step: assert property (
    @(posedge clk) disable iff (rst)
    operation_enable_bit && count_tick |=> prescaler == $past(prescaler) + 11'h001)
    else $error("prescaler did not advance on a watch clock tick");

  a_prescaler_hold: assert property (
    @(posedge clk) disable iff (rst)
    operation_enable_bit && !count_tick |=> $stable(prescaler))
    else $error("prescaler moved without a watch clock tick");

  a_counter_step: assert property (
    @(posedge clk) disable iff (rst)
    counting && primed && segment_wrap |=> counter == $past(counter) + 5'h01)
    else $error("counter did not advance at a prescaler segment end");

  a_counter_hold: assert property (
    @(posedge clk) disable iff (rst)
    counting && !segment_wrap |=> $stable(counter))
    else $error("counter moved inside a prescaler segment");

  a_sub_source_tick: assert property (
    @(posedge clk) disable iff (rst)
    clock_code == CLK_SUBCLOCK && operation_enable_bit |=> count_tick == $past(sub_tick))
    else $error("subclock source did not follow the synchronised pin");

  a_interval_needs_enable: assert property (
    @(posedge clk) disable iff (rst)
    !operation_enable_bit |=> !interval_tick_irq)
    else $error("interval tick while operation disabled");

  a_select_read_zero: assert property (
    @(posedge clk) disable iff (rst)
    bus_req.read && bus_req.addr == CLOCK_SELECT_ADDR |=> rdata[7:2] == 6'h00)
    else $error("clock select upper bits not zero");

  a_byte_write_mode: assert property (
    @(posedge clk) disable iff (rst)
    bus_req.byte_write && bus_req.addr == MODE_CONTROL_ADDR
    |=> watch_mode_control == $past(bus_req.wdata))
    else $error("byte write to mode control lost");

endmodule

`default_nettype wire

/* tb/watch_interval_timer_tb_top.sv */
/*
  Self-checking bench for the watch and interval timer: register reset values,
  byte and bit writes, main divider and subclock tick timing, and the stop controls.
  Assumes the design's own assertions guard pulse shapes; the bench drives the
  subclock pin itself with an 8-cycle period so that long periods stay short.
*/
`timescale 1ns/100ps
`default_nettype none

module watch_interval_timer_tb_top;
  import watch_pkg::*;

  logic        clk;
  logic        rst;
  bus_req_s    bus_req;
  logic [7:0]  rdata;
  logic        sub_clock_pin = 1'b0;
  logic        watch_tick_irq;
  logic        interval_tick_irq;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          wcnt = 0;
  int          icnt = 0;
  logic [31:0] seed;
  logic [2:0]  sub_phase = 3'h0;
  logic [2:0]  ic;
  logic [1:0]  wc;
  logic [3:0]  main_codes [6] = '{CLK_MAIN_DIV128, CLK_MAIN_DIV192, CLK_MAIN_DIV256,
                                  CLK_MAIN_DIV384, CLK_MAIN_DIV512, CLK_MAIN_DIV576};
  int          main_divs [6]  = '{1 << 7, 3 << 6, 1 << 8, 3 << 7, 1 << 9, 9 << 6};

  watch_interval_timer #(.HAS_FAST_SELECT(1'b1)) watch_interval_timer_i (
    .clk               (clk),
    .rst               (rst),
    .bus_req           (bus_req),
    .rdata             (rdata),
    .sub_clock_pin     (sub_clock_pin),
    .watch_tick_irq    (watch_tick_irq),
    .interval_tick_irq (interval_tick_irq)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // The pin is made on clk so every subclock tick is exactly 8 cycles apart.
  always @(posedge clk) begin
    cyc           <= cyc + 1;
    sub_phase     <= sub_phase + 3'h1;
    sub_clock_pin <= sub_phase[2];
    if (watch_tick_irq === 1'b1) wcnt <= wcnt + 1;
    if (interval_tick_irq === 1'b1) icnt <= icnt + 1;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  function automatic int tick_len(input logic [1:0] code);
    case (code)
      2'h0: return 1 << 14;
      2'h1: return 1 << 13;
      2'h2: return 1 << 5;
      default: return 1 << 4;
    endcase
  endfunction

  function automatic int interval_len(input int div, input logic [2:0] code);
    return div << (4 + code);
  endfunction

  function automatic logic [7:0] mode_byte(input logic src, input logic [2:0] ivl,
                                           input logic [1:0] tick, input logic [1:0] ctl);
    return {src, ivl, tick, ctl};
  endfunction

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_span(input string name, input int exp, input int got, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr       <= a;
    bus_req.wdata      <= d;
    bus_req.byte_write <= 1'b1;
    @(posedge clk);
    bus_req.byte_write <= 1'b0;
  endtask

  task automatic bw(input logic [31:0] a, input logic [2:0] s, input logic v);
    @(posedge clk);
    bus_req.addr      <= a;
    bus_req.bit_sel   <= s;
    bus_req.bit_value <= v;
    bus_req.bit_write <= 1'b1;
    @(posedge clk);
    bus_req.bit_write <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [31:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.read <= 1'b1;
    @(posedge clk);
    bus_req.read <= 1'b0;
    #1;
    check_val(name, exp, rdata);
  endtask

  task automatic wait_irq(input logic sel, output int t);
    int   n;
    logic f;
    n = 0;
    f = 1'b0;
    while (f !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      f = sel ? watch_tick_irq : interval_tick_irq;
      n++;
    end
    t = cyc;
    check_val("irq arrival", 8'h01, {7'h0, f});
    @(posedge clk);
    #1;
    f = sel ? watch_tick_irq : interval_tick_irq;
    check_val("irq pulse width", 8'h00, {7'h0, f});
  endtask

  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    $display("mismatch watchdog expected finish seen timeout");
    test_done;
  end

  initial begin
    logic [31:0] r;
    int          t0;
    int          t1;
    int          t2;
    int          w0;
    int          i0;
    int          p;
    bus_req = '0;
    rst = 1'b1;
    seed = 32'hb43e38df;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk("mode reset", MODE_CONTROL_ADDR, 8'h00);
    rchk("select reset", CLOCK_SELECT_ADDR, 8'h00);
    rchk("fast reset", FAST_CLOCK_SELECT_ADDR, 8'h00);
    seed = lfsr_next(seed);
    r = seed;
    wr(CLOCK_SELECT_ADDR, r[7:0]);
    rchk("select bits", CLOCK_SELECT_ADDR, r[7:0] & 8'h03);
    wr(FAST_CLOCK_SELECT_ADDR, r[15:8]);
    rchk("fast bits", FAST_CLOCK_SELECT_ADDR, r[15:8] & 8'h01);
    bw(CLOCK_SELECT_ADDR, 3'h0, ~r[0]);
    rchk("select bit write", CLOCK_SELECT_ADDR, r[7:0] & 8'h03);
    wr(MODE_CONTROL_ADDR, r[23:16] & 8'hfc);
    bw(MODE_CONTROL_ADDR, 3'h6, ~r[22]);
    rchk("mode bit write", MODE_CONTROL_ADDR, (r[23:16] & 8'hfc) ^ 8'h40);
    wr(32'h0ffff362, 8'hff);
    rchk("unmapped read", 32'h0ffff362, 8'h00);
    rchk("mode after stray", MODE_CONTROL_ADDR, (r[23:16] & 8'hfc) ^ 8'h40);
    wr(MODE_CONTROL_ADDR, 8'h00);
    // Clocks are set while stopped, then the enable alone is written.
    for (int k = 0; k < 6; k++) begin
      wr(FAST_CLOCK_SELECT_ADDR, {7'h0, main_codes[k][3]});
      wr(CLOCK_SELECT_ADDR, {6'h0, main_codes[k][2:1]});
      wr(MODE_CONTROL_ADDR, mode_byte(main_codes[k][0], 3'h0, 2'h3, 2'h0));
      w0 = wcnt;
      wr(MODE_CONTROL_ADDR, mode_byte(main_codes[k][0], 3'h0, 2'h3, 2'h1));
      t0 = cyc;
      wait_irq(1'b0, t1);
      check_span("main divider", interval_len(main_divs[k], 3'h0), t1 - t0, 4);
      check_span("watch held off", 0, wcnt - w0, 0);
      wr(MODE_CONTROL_ADDR, 8'h00);
    end
    wr(FAST_CLOCK_SELECT_ADDR, 8'h00);
    wr(CLOCK_SELECT_ADDR, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(MODE_CONTROL_ADDR, mode_byte(1'b1, k[2:0], 2'h3, 2'h0));
      w0 = wcnt;
      wr(MODE_CONTROL_ADDR, mode_byte(1'b1, k[2:0], 2'h3, 2'h1));
      t0 = cyc;
      wait_irq(1'b0, t1);
      check_span("interval code", interval_len(8, k[2:0]), t1 - t0, 16);
      check_span("watch counter off", 0, wcnt - w0, 0);
      wr(MODE_CONTROL_ADDR, 8'h00);
    end
    seed = lfsr_next(seed);
    ic = {1'b0, seed[1:0]};
    wc = {1'b1, seed[2]};
    p = tick_len(wc) * 8;
    wr(MODE_CONTROL_ADDR, mode_byte(1'b1, ic, wc, 2'h0));
    wr(MODE_CONTROL_ADDR, mode_byte(1'b1, ic, wc, 2'h3));
    t0 = cyc;
    wait_irq(1'b1, t1);
    check_span("first watch tick", 512 * 8 + p, t1 - t0, 16);
    wait_irq(1'b1, t2);
    check_span("watch period", p, t2 - t1, 0);
    wait_irq(1'b0, t1);
    wait_irq(1'b0, t2);
    check_span("interval beside watch", interval_len(8, ic), t2 - t1, 0);
    bw(MODE_CONTROL_ADDR, 3'h1, 1'b0);
    w0 = wcnt;
    wait_irq(1'b0, t1);
    wait_irq(1'b0, t2);
    check_span("interval alone", interval_len(8, ic), t2 - t1, 0);
    check_span("counter cleared", 0, wcnt - w0, 0);
    bw(MODE_CONTROL_ADDR, 3'h0, 1'b0);
    w0 = wcnt;
    i0 = icnt;
    repeat (2000) @(posedge clk);
    check_span("stopped watch", 0, wcnt - w0, 0);
    check_span("stopped interval", 0, icnt - i0, 0);
    bw(MODE_CONTROL_ADDR, 3'h1, 1'b1);
    bw(MODE_CONTROL_ADDR, 3'h0, 1'b1);
    t0 = cyc;
    wait_irq(1'b1, t1);
    check_span("rearmed watch tick", 512 * 8 + p, t1 - t0, 16);
    test_done;
  end
endmodule

`default_nettype wire
